//--- common/par_mem_if.sv
// Byte request channel between the resolver core and its memory master.
// Assumes both ends run on the system clock.
`timescale 1ns/100ps
interface par_mem_if;
	logic cmd_valid;
	logic cmd_ready;
	logic cmd_we;
	logic [31:0] cmd_addr;
	logic [7:0] cmd_wdata;
	logic rsp_valid;
	logic [7:0] rsp_data;
	modport client (output cmd_valid, output cmd_we, output cmd_addr, output cmd_wdata,
		input cmd_ready, input rsp_valid, input rsp_data);
	modport server (input cmd_valid, input cmd_we, input cmd_addr, input cmd_wdata,
		output cmd_ready, output rsp_valid, output rsp_data);
endinterface : par_mem_if

//--- common/par_pkg.sv
// Constants, state codes and helpers shared by the private address resolver.
// Assumes a 50 MHz system clock and byte-wide access to system RAM.
//
// What this block does
// - Keys are read from the key-list pointer.
// - Key n sits sixteen bytes times n.
// - Writing 1 at 0x000 starts resolution.
// - Stop task at 0x008 halts resolution.
// - Done flag at 0x100 set on finish.
// - Match flag 0x104, no-match flag 0x108.
// - Enable-set register at 0x304 sets bits.
// - Enable-clear register at 0x308 clears bits.
// - Status at 0x400 holds matched key index.
// - Enable field 0x500: 0 off, 3 on.
// - Key count at 0x504, 1 to 16.
// - Key-list pointer register at 0x508.
// - Target address pointer register at 0x510.
// - Work area pointer register at 0x514.
// - Keys tried in order, stop at match.
// - Event flags stay set until written 0.
// - Memory accesses finish before events rise.
package par_pkg;
	localparam logic [11:0] OFS_START = 12'h000;
	localparam logic [11:0] OFS_STOP = 12'h008;
	localparam logic [11:0] OFS_DONE = 12'h100;
	localparam logic [11:0] OFS_MATCH = 12'h104;
	localparam logic [11:0] OFS_NOMATCH = 12'h108;
	localparam logic [11:0] OFS_IRQ_SET = 12'h304;
	localparam logic [11:0] OFS_IRQ_CLR = 12'h308;
	localparam logic [11:0] OFS_STATUS = 12'h400;
	localparam logic [11:0] OFS_ON_OFF = 12'h500;
	localparam logic [11:0] OFS_KEY_COUNT = 12'h504;
	localparam logic [11:0] OFS_KEY_BASE = 12'h508;
	localparam logic [11:0] OFS_TARGET_BASE = 12'h510;
	localparam logic [11:0] OFS_WORK_BASE = 12'h514;
	localparam int BIT_DONE = 0;
	localparam int BIT_MATCH = 1;
	localparam int BIT_NOMATCH = 2;
	localparam logic [1:0] ON_OFF_RESET = 2'h0;
	localparam logic [1:0] ON_OFF_ENABLED = 2'h3;
	localparam logic [4:0] KEY_COUNT_RESET = 5'h01;
	localparam logic [3:0] KEY_INDEX_LAST = 4'hF;
	localparam logic [3:0] KEY_BYTE_LAST = 4'hF;
	localparam logic [3:0] ADDR_BYTE_LAST = 4'h5;
	localparam logic [3:0] HASH_BYTE_LAST = 4'h2;
	localparam logic [3:0] HASH_ROUNDS = 4'h8;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [2:0] {
		S_IDLE = 3'b000,
		S_ADDR = 3'b001,
		S_KEY = 3'b010,
		S_HASH = 3'b011,
		S_WORK = 3'b100,
		S_CHECK = 3'b101
	} par_state_t;

	// Merges write data into an old word lane by lane.
	function automatic logic [31:0] par_merge(input logic [31:0] old_val, input logic [31:0] new_val,
		input logic [3:0] strb);
		logic [31:0] res;
		res = old_val;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) begin
				res[i*8 +: 8] = new_val[i*8 +: 8];
			end
		end
		return res;
	endfunction : par_merge
endpackage : par_pkg

//--- sim/par_ram_model.sv
// System RAM model for the resolver's byte memory port, with a random wait per request.
// Assumes the bench loads mem before a run and seeds the random source.
`timescale 1ns/100ps
module par_ram_model (
	input wire logic i_clk,
	input wire logic i_reset_n,
	input wire logic i_req,
	input wire logic i_we,
	input wire logic [31:0] i_addr,
	input wire logic [7:0] i_wdata,
	output logic o_ack,
	output logic [7:0] o_rdata
);
	logic [7:0] mem [0:4095];
	logic [1:0] wait_n;
	int rd_n = 0;
	int wr_n = 0;

	// Read data toggles in every cycle but a read ack, so a stale byte never passes for a valid one.
	always @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			o_ack <= 1'b0;
			o_rdata <= 8'h00;
			wait_n <= 2'h0;
		end else begin
			o_ack <= 1'b0;
			o_rdata <= ~o_rdata;
			if (i_req && !o_ack) begin
				if (wait_n != 2'h0) begin
					wait_n <= wait_n - 2'h1;
				end else begin
					o_ack <= 1'b1;
					wait_n <= 2'($urandom);
					if (i_we) begin
						mem[i_addr[11:0]] <= i_wdata;
						wr_n <= wr_n + 1;
					end else begin
						o_rdata <= mem[i_addr[11:0]];
						rd_n <= rd_n + 1;
					end
				end
			end
		end
	end
endmodule : par_ram_model

//--- sim/par_top_props.sv
// Checker for register-bus and memory-port timing of par_top.
// Assumes one clock domain and sees only the top ports.
`timescale 1ns/100ps
module par_top_props
	import par_pkg::*;
(
	input wire logic I_CLK_SYS,
	input wire logic I_RESET_N,
	input wire logic I_ARVALID,
	input wire logic O_ARREADY,
	input wire logic [11:0] I_ARADDR,
	input wire logic O_RVALID,
	input wire logic [31:0] O_RDATA,
	input wire logic [1:0] O_RRESP,
	input wire logic O_BVALID,
	input wire logic I_BREADY,
	input wire logic [1:0] O_BRESP,
	input wire logic O_MEM_REQ,
	input wire logic O_MEM_WE,
	input wire logic [31:0] O_MEM_ADDR,
	input wire logic I_MEM_ACK,
	input wire logic O_IRQ
);
	default clocking cb @(posedge I_CLK_SYS); endclocking
	default disable iff (!I_RESET_N);
	sequence s_ar(logic [11:0] a); I_ARVALID && O_ARREADY && I_ARADDR == a; endsequence
	property p_b_hold; O_BVALID && !I_BREADY |=> O_BVALID && $stable(O_BRESP); endproperty
	a_b_hold: assert property (p_b_hold) else $error("write response dropped");
	property p_rd_lat; I_ARVALID && O_ARREADY |=> O_RVALID; endproperty
	a_rd_lat: assert property (p_rd_lat) else $error("read answer late");
	property p_status; s_ar(OFS_STATUS) |=> O_RDATA[31:4] == 28'h0 && O_RRESP == RESP_OKAY; endproperty
	a_status: assert property (p_status) else $error("status wider than index");
	property p_on_off; s_ar(OFS_ON_OFF) |=> O_RDATA[31:2] == 30'h0; endproperty
	a_on_off: assert property (p_on_off) else $error("enable field too wide");
	property p_irq_rd; s_ar(OFS_IRQ_SET) or s_ar(OFS_IRQ_CLR) |=> O_RDATA[31:3] == 29'h0; endproperty
	a_irq_rd: assert property (p_irq_rd) else $error("irq enable too wide");
	property p_unmapped; s_ar(12'h004) |=> O_RRESP == RESP_SLVERR && O_RDATA == 32'h0; endproperty
	a_unmapped: assert property (p_unmapped) else $error("unmapped read accepted");
	property p_mem_hold; O_MEM_REQ && !I_MEM_ACK |=> O_MEM_REQ && $stable(O_MEM_ADDR) && $stable(O_MEM_WE);
	endproperty
	a_mem_hold: assert property (p_mem_hold) else $error("memory request changed");
	property p_mem_gap; I_MEM_ACK |=> !O_MEM_REQ; endproperty
	a_mem_gap: assert property (p_mem_gap) else $error("memory request too soon");
	property p_irq_quiet; $rose(O_IRQ) && !O_BVALID |-> !O_MEM_REQ; endproperty
	a_irq_quiet: assert property (p_irq_quiet) else $error("event before memory done");
	c_irq: cover property ($rose(O_IRQ));
	c_mem_wr: cover property (I_MEM_ACK && O_MEM_WE);
	c_slverr: cover property (O_RVALID && O_RRESP == RESP_SLVERR);
endmodule : par_top_props

bind par_top par_top_props chk_u (.I_CLK_SYS, .I_RESET_N, .I_ARVALID, .O_ARREADY, .I_ARADDR, .O_RVALID,
	.O_RDATA, .O_RRESP, .O_BVALID, .I_BREADY, .O_BRESP, .O_MEM_REQ, .O_MEM_WE, .O_MEM_ADDR, .I_MEM_ACK, .O_IRQ);

//--- sim/test_par_top.sv
// Self-checking bench for par_top: bus master tasks, RAM model and a queue of expected answers.
// Assumes par_ram_model stands in for system RAM and the checker is bound to the design.
`timescale 1ns/100ps
module test_par_top
	import par_pkg::*;
();
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic awv = 1'b0, wv = 1'b0, bry = 1'b0, arv = 1'b0, rry = 1'b0;
	logic [11:0] awa = 12'h000, ara = 12'h000;
	logic [31:0] wd = 32'h00000000;
	logic [3:0] ws = 4'hF;
	logic aw_rdy, w_rdy, ar_rdy, bv, rv, req, we, ack, irq;
	logic [1:0] br, rr;
	logic [31:0] rdat, maddr;
	logic [7:0] mwd, mrd;
	logic [33:0] exp_q[$];
	int n_errors = 0;
	int check_count = 0;
	int r0;

	always #10 clk = ~clk;

	par_top dut_u (.I_CLK_SYS(clk), .I_RESET_N(rst_n), .I_AWVALID(awv), .O_AWREADY(aw_rdy), .I_AWADDR(awa),
		.I_WVALID(wv), .O_WREADY(w_rdy), .I_WDATA(wd), .I_WSTRB(ws), .O_BVALID(bv), .I_BREADY(bry), .O_BRESP(br),
		.I_ARVALID(arv), .O_ARREADY(ar_rdy), .I_ARADDR(ara), .O_RVALID(rv), .I_RREADY(rry), .O_RDATA(rdat),
		.O_RRESP(rr), .O_MEM_REQ(req), .O_MEM_WE(we), .O_MEM_ADDR(maddr), .O_MEM_WDATA(mwd), .I_MEM_ACK(ack),
		.I_MEM_RDATA(mrd), .O_IRQ(irq));
	par_ram_model ram_u (.i_clk(clk), .i_reset_n(rst_n), .i_req(req), .i_we(we), .i_addr(maddr),
		.i_wdata(mwd), .o_ack(ack), .o_rdata(mrd));

	task automatic chk(input string nm, input logic [33:0] e, input logic [33:0] g);
		check_count++;
		if (g !== e) begin
			n_errors++;
			$display("MISMATCH %s expected %h seen %h", nm, e, g);
		end
	endtask : chk

	task automatic print_verdict();
		$display("Comparisons %0d, mismatches %0d", check_count, n_errors);
		if (n_errors == 0 && check_count > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : print_verdict

	task automatic tmo();
		chk("wait", 34'h0, 34'h1);
		print_verdict();
	endtask : tmo

	// Answers are compared by the monitor below; the tasks only queue what they expect.
	task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] e = RESP_OKAY);
		int n = 0;
		exp_q.push_back({e, 32'h00000000});
		awa <= a;
		wd <= d;
		awv <= 1'b1;
		wv <= 1'b1;
		bry <= 1'b1;
		do begin
			@(posedge clk);
			n++;
			if (awv && aw_rdy === 1'b1) awv <= 1'b0;
			if (wv && w_rdy === 1'b1) wv <= 1'b0;
		end while (bv !== 1'b1 && n < 200);
		if (n >= 200) tmo();
	endtask : wr

	task automatic rd(input logic [11:0] a, input logic [31:0] d, input logic [1:0] e = RESP_OKAY);
		int n = 0;
		exp_q.push_back({e, d});
		ara <= a;
		arv <= 1'b1;
		rry <= 1'b1;
		do begin
			@(posedge clk);
			n++;
			if (arv && ar_rdy === 1'b1) arv <= 1'b0;
		end while (rv !== 1'b1 && n < 200);
		if (n >= 200) tmo();
	endtask : rd

	task automatic wrr(input logic [11:0] a, input logic [31:0] d);
		wr(a, d);
		rd(a, d);
	endtask : wrr

	always @(posedge clk) begin
		if (bv === 1'b1 && bry && exp_q.size() > 0) chk("bresp", exp_q.pop_front(), {br, 32'h00000000});
		if (rv === 1'b1 && rry && exp_q.size() > 0) chk("rdata", exp_q.pop_front(), {rr, rdat});
	end

	function automatic logic [23:0] hsh(input logic [127:0] k, input logic [23:0] p);
		logic [23:0] h;
		h = p;
		for (int i = 0; i < int'(HASH_ROUNDS); i++) begin
			h = {h[18:0], h[23:19]} ^ k[23:0] ^ {8'h00, k[127:112]};
			k = {k[15:0], k[127:16]};
		end
		return h;
	endfunction : hsh

	// Address matches key m; with m not below cnt that key lies past the list and must not be tried.
	task automatic go(input int m, input int cnt);
		logic [127:0] k;
		logic [23:0] p;
		logic [23:0] h;
		int t;
		int w0;
		int n = 0;
		p = 24'($urandom);
		for (int i = 0; i < 16; i++) k[i*8 +: 8] = ram_u.mem[256 + 16*m + i];
		h = hsh(k, p);
		for (int i = 0; i < 3; i++) begin
			ram_u.mem[i] = h[i*8 +: 8];
			ram_u.mem[i+3] = p[i*8 +: 8];
		end
		t = (m < cnt) ? m + 1 : cnt;
		r0 = ram_u.rd_n;
		w0 = ram_u.wr_n;
		wr(OFS_KEY_COUNT, 32'(cnt));
		wr(OFS_START, 32'h00000001);
		wr(OFS_START, 32'h00000001);
		while (irq !== 1'b1 && n < 5000) begin
			@(posedge clk);
			n++;
		end
		if (n >= 5000) tmo();
		chk("reads", 34'(6 + 16*t), 34'(ram_u.rd_n - r0));
		chk("writes", 34'(3*t), 34'(ram_u.wr_n - w0));
		rd(OFS_DONE, 32'h00000001);
		rd(OFS_MATCH, 32'(m < cnt));
		rd(OFS_NOMATCH, 32'(m >= cnt));
		if (m < cnt) begin
			rd(OFS_STATUS, 32'(m));
			chk("work", 34'(h), 34'({ram_u.mem[514], ram_u.mem[513], ram_u.mem[512]}));
		end
		wr(OFS_DONE, 32'h00000001);
		rd(OFS_DONE, 32'h00000001);
		wr(OFS_DONE, 32'h00000000);
		wr(OFS_MATCH, 32'h00000000);
		wr(OFS_NOMATCH, 32'h00000000);
		rd(OFS_DONE, 32'h00000000);
		chk("irq", 34'h0, 34'(irq));
	endtask : go

	initial begin
		void'($urandom(38));
		for (int i = 0; i < 4096; i++) ram_u.mem[i] = 8'($urandom);
		repeat (5) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		rd(OFS_ON_OFF, 32'h00000000);
		rd(OFS_KEY_COUNT, 32'h00000001);
		wr(OFS_STATUS, 32'h0000000F);
		rd(OFS_STATUS, 32'h00000000);
		rd(OFS_IRQ_SET, 32'h00000000);
		rd(12'h004, 32'h00000000, RESP_SLVERR);
		wr(12'h50C, 32'h00000001, RESP_SLVERR);
		wrr(OFS_KEY_BASE, 32'h00000100);
		wrr(OFS_TARGET_BASE, 32'h00000000);
		wrr(OFS_WORK_BASE, 32'h00000200);
		ws <= 4'h1;
		wr(OFS_WORK_BASE, 32'hFFFFFF00);
		ws <= 4'hF;
		rd(OFS_WORK_BASE, 32'h00000200);
		wr(OFS_IRQ_SET, 32'h00000007);
		wr(OFS_IRQ_SET, 32'h00000000);
		rd(OFS_IRQ_CLR, 32'h00000007);
		wr(OFS_IRQ_CLR, 32'h00000006);
		rd(OFS_IRQ_SET, 32'h00000001);
		r0 = ram_u.rd_n;
		wr(OFS_START, 32'h00000001);
		repeat (100) @(posedge clk);
		chk("idle reads", 34'h0, 34'(ram_u.rd_n - r0));
		rd(OFS_DONE, 32'h00000000);
		wrr(OFS_ON_OFF, 32'h00000003);
		go(2, 4);
		go(3, 3);
		go(15, 16);
		go(0, 1);
		ram_u.mem[0] = ~ram_u.mem[0];
		wr(OFS_KEY_COUNT, 32'h00000010);
		wr(OFS_START, 32'h00000001);
		repeat (30) @(posedge clk);
		wr(OFS_STOP, 32'h00000001);
		repeat (20) @(posedge clk);
		r0 = ram_u.rd_n;
		repeat (200) @(posedge clk);
		chk("stop reads", 34'h0, 34'(ram_u.rd_n - r0));
		rd(OFS_DONE, 32'h00000000);
		print_verdict();
	end
endmodule : test_par_top

//--- verilog/par_hash.sv
// Keyed 24-bit hash engine of fixed latency.
// Assumes the key and random part are valid in the cycle that i_start is high.
`timescale 1ns/100ps
module par_hash
	import par_pkg::*;
(
	input wire logic i_clk,
	input wire logic i_reset_n,
	input wire logic i_start,
	input wire logic [127:0] i_key,
	input wire logic [23:0] i_prand,
	output logic o_done,
	output logic [23:0] o_hash
);
	// A stand-in mixing network: the real cipher slots in here with the same handshake.
	logic [127:0] key_rot;
	logic [3:0] round;
	logic busy;

	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			busy <= 1'b0;
			round <= 4'h0;
			key_rot <= '0;
			o_hash <= 24'h000000;
			o_done <= 1'b0;
		end else begin
			o_done <= 1'b0;
			if (i_start) begin
				busy <= 1'b1;
				round <= 4'h0;
				key_rot <= i_key;
				o_hash <= i_prand;
			end else if (busy) begin
				o_hash <= {o_hash[18:0], o_hash[23:19]} ^ key_rot[23:0] ^ {8'h00, key_rot[127:112]};
				key_rot <= {key_rot[15:0], key_rot[127:16]};
				round <= round + 4'h1;
				if (round == HASH_ROUNDS - 4'h1) begin
					busy <= 1'b0;
					o_done <= 1'b1;
				end
			end
		end
	end
endmodule : par_hash

//--- verilog/par_mem_master.sv
// Memory master: turns one byte command into a held request on the RAM port.
// Assumes the RAM acknowledges each request with a one-cycle ack carrying read data.
`timescale 1ns/100ps
module par_mem_master (
	input wire logic i_clk,
	input wire logic i_reset_n,
	par_mem_if.server bus,
	output logic o_req,
	output logic o_we,
	output logic [31:0] o_addr,
	output logic [7:0] o_wdata,
	input wire logic i_ack,
	input wire logic [7:0] i_rdata
);
	assign bus.cmd_ready = !o_req;

	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			o_req <= 1'b0;
			o_we <= 1'b0;
			o_addr <= 32'h00000000;
			o_wdata <= 8'h00;
		end else if (bus.cmd_valid && !o_req) begin
			o_req <= 1'b1;
			o_we <= bus.cmd_we;
			o_addr <= bus.cmd_addr;
			o_wdata <= bus.cmd_wdata;
		end else if (i_ack) begin
			o_req <= 1'b0;
		end
	end

	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			bus.rsp_valid <= 1'b0;
			bus.rsp_data <= 8'h00;
		end else begin
			bus.rsp_valid <= o_req && i_ack;
			if (o_req && i_ack) begin
				bus.rsp_data <= i_rdata;
			end
		end
	end
endmodule : par_mem_master

//--- verilog/par_top.sv
// Private address resolver: AXI4-Lite register slave, key walk and memory sequencing.
// Assumes system RAM answers each byte request on the memory port in finite time.
//
// The AXI4-Lite slave port was left to the implementer.
`timescale 1ns/100ps
module par_top
	import par_pkg::*;
(
	input wire logic I_CLK_SYS,
	input wire logic I_RESET_N,
	input wire logic I_AWVALID,
	output logic O_AWREADY,
	input wire logic [11:0] I_AWADDR,
	input wire logic I_WVALID,
	output logic O_WREADY,
	input wire logic [31:0] I_WDATA,
	input wire logic [3:0] I_WSTRB,
	output logic O_BVALID,
	input wire logic I_BREADY,
	output logic [1:0] O_BRESP,
	input wire logic I_ARVALID,
	output logic O_ARREADY,
	input wire logic [11:0] I_ARADDR,
	output logic O_RVALID,
	input wire logic I_RREADY,
	output logic [31:0] O_RDATA,
	output logic [1:0] O_RRESP,
	output logic O_MEM_REQ,
	output logic O_MEM_WE,
	output logic [31:0] O_MEM_ADDR,
	output logic [7:0] O_MEM_WDATA,
	input wire logic I_MEM_ACK,
	input wire logic [7:0] I_MEM_RDATA,
	output logic O_IRQ
);
	function automatic logic reg_known(input logic [11:0] a);
		case (a)
			OFS_START, OFS_STOP, OFS_DONE, OFS_MATCH, OFS_NOMATCH, OFS_IRQ_SET, OFS_IRQ_CLR,
			OFS_STATUS, OFS_ON_OFF, OFS_KEY_COUNT, OFS_KEY_BASE, OFS_TARGET_BASE,
			OFS_WORK_BASE: reg_known = 1'b1;
			default: reg_known = 1'b0;
		endcase
	endfunction : reg_known

	par_mem_if mem();

	par_mem_master u_mem (
		.i_clk(I_CLK_SYS),
		.i_reset_n(I_RESET_N),
		.bus(mem.server),
		.o_req(O_MEM_REQ),
		.o_we(O_MEM_WE),
		.o_addr(O_MEM_ADDR),
		.o_wdata(O_MEM_WDATA),
		.i_ack(I_MEM_ACK),
		.i_rdata(I_MEM_RDATA)
	);

	logic hash_start;
	logic hash_done;
	logic [23:0] hash_val;
	logic [127:0] key_buf;
	logic [47:0] addr_buf;

	par_hash u_hash (
		.i_clk(I_CLK_SYS),
		.i_reset_n(I_RESET_N),
		.i_start(hash_start),
		.i_key(key_buf),
		.i_prand(addr_buf[47:24]),
		.o_done(hash_done),
		.o_hash(hash_val)
	);

	// Register bus: write address and data are caught separately, then applied together.
	logic aw_held;
	logic w_held;
	logic [11:0] aw_addr;
	logic [31:0] w_data;
	logic [3:0] w_strb;
	logic wr_fire;
	logic wr_bit0;
	logic wr_zero0;

	assign O_AWREADY = !aw_held;
	assign O_WREADY = !w_held;
	assign wr_fire = aw_held && w_held && !O_BVALID;
	assign wr_bit0 = w_strb[0] && w_data[0];
	assign wr_zero0 = w_strb[0] && !w_data[0];

	always_ff @(posedge I_CLK_SYS or negedge I_RESET_N) begin
		if (!I_RESET_N) begin
			aw_held <= 1'b0;
			aw_addr <= 12'h000;
		end else if (I_AWVALID && !aw_held) begin
			aw_held <= 1'b1;
			aw_addr <= I_AWADDR;
		end else if (wr_fire) begin
			aw_held <= 1'b0;
		end
	end

	always_ff @(posedge I_CLK_SYS or negedge I_RESET_N) begin
		if (!I_RESET_N) begin
			w_held <= 1'b0;
			w_data <= 32'h00000000;
			w_strb <= 4'h0;
		end else if (I_WVALID && !w_held) begin
			w_held <= 1'b1;
			w_data <= I_WDATA;
			w_strb <= I_WSTRB;
		end else if (wr_fire) begin
			w_held <= 1'b0;
		end
	end

	always_ff @(posedge I_CLK_SYS or negedge I_RESET_N) begin
		if (!I_RESET_N) begin
			O_BVALID <= 1'b0;
			O_BRESP <= RESP_OKAY;
		end else if (wr_fire) begin
			O_BVALID <= 1'b1;
			O_BRESP <= reg_known(aw_addr) ? RESP_OKAY : RESP_SLVERR;
		end else if (I_BREADY) begin
			O_BVALID <= 1'b0;
		end
	end

	// Software-visible configuration.
	logic [1:0] on_off;
	logic [4:0] key_count;
	logic [31:0] key_base;
	logic [31:0] target_base;
	logic [31:0] work_base;
	logic [2:0] irq_enable;
	logic enabled;

	assign enabled = (on_off == ON_OFF_ENABLED);

	always_ff @(posedge I_CLK_SYS or negedge I_RESET_N) begin
		if (!I_RESET_N) begin
			on_off <= ON_OFF_RESET;
			key_count <= KEY_COUNT_RESET;
			key_base <= 32'h00000000;
			target_base <= 32'h00000000;
			work_base <= 32'h00000000;
		end else if (wr_fire) begin
			case (aw_addr)
				OFS_ON_OFF: on_off <= 2'(par_merge({30'h00000000, on_off}, w_data, w_strb));
				OFS_KEY_COUNT: key_count <= 5'(par_merge({27'h0000000, key_count}, w_data, w_strb));
				OFS_KEY_BASE: key_base <= par_merge(key_base, w_data, w_strb);
				OFS_TARGET_BASE: target_base <= par_merge(target_base, w_data, w_strb);
				OFS_WORK_BASE: work_base <= par_merge(work_base, w_data, w_strb);
				default: begin
				end
			endcase
		end
	end

	always_ff @(posedge I_CLK_SYS or negedge I_RESET_N) begin
		if (!I_RESET_N) begin
			irq_enable <= 3'h0;
		end else if (wr_fire && aw_addr == OFS_IRQ_SET) begin
			irq_enable <= irq_enable | w_data[2:0];
		end else if (wr_fire && aw_addr == OFS_IRQ_CLR) begin
			irq_enable <= irq_enable & ~w_data[2:0];
		end
	end

	// Tasks: only a 1 in bit 0 triggers, and only while the block is on.
	logic start_trig;
	logic stop_trig;

	assign start_trig = wr_fire && aw_addr == OFS_START && wr_bit0 && enabled;
	assign stop_trig = wr_fire && aw_addr == OFS_STOP && wr_bit0 && enabled;

	// Resolution sequencer.
	par_state_t state;
	logic [3:0] byte_cnt;
	logic [3:0] key_idx;
	logic [4:0] run_count;
	logic pending;
	logic abort;
	logic [23:0] work_hash;
	logic [3:0] matched_key;
	logic ev_done;
	logic ev_match;
	logic ev_nomatch;
	logic key_hit;
	logic last_key;
	logic mem_phase;
	logic cmd_fire;

	assign mem_phase = (state == S_ADDR) || (state == S_KEY) || (state == S_WORK);
	assign mem.cmd_valid = mem_phase && !pending && !abort;
	assign cmd_fire = mem.cmd_valid && mem.cmd_ready;
	assign key_hit = (work_hash == addr_buf[23:0]);
	// A count of 0 still tries key 0; counts above 16 stop at key 15.
	assign last_key = ({1'b0, key_idx} + 5'h01 >= run_count) || (key_idx == KEY_INDEX_LAST);

	always_comb begin
		mem.cmd_we = 1'b0;
		mem.cmd_wdata = 8'h00;
		mem.cmd_addr = target_base + {28'h0000000, byte_cnt};
		case (state)
			S_KEY: mem.cmd_addr = key_base + {24'h000000, key_idx, byte_cnt};
			S_WORK: begin
				mem.cmd_we = 1'b1;
				mem.cmd_addr = work_base + {28'h0000000, byte_cnt};
				mem.cmd_wdata = work_hash[byte_cnt[1:0]*8 +: 8];
			end
			default: begin
			end
		endcase
	end

	always_ff @(posedge I_CLK_SYS or negedge I_RESET_N) begin
		if (!I_RESET_N) begin
			pending <= 1'b0;
		end else if (cmd_fire) begin
			pending <= 1'b1;
		end else if (mem.rsp_valid) begin
			pending <= 1'b0;
		end
	end

	// A stop is held until the outstanding byte returns, so no access outlives the run.
	always_ff @(posedge I_CLK_SYS or negedge I_RESET_N) begin
		if (!I_RESET_N) begin
			abort <= 1'b0;
		end else if (state == S_IDLE) begin
			abort <= 1'b0;
		end else if (stop_trig) begin
			abort <= 1'b1;
		end
	end

	always_ff @(posedge I_CLK_SYS or negedge I_RESET_N) begin
		if (!I_RESET_N) begin
			state <= S_IDLE;
			byte_cnt <= 4'h0;
			key_idx <= 4'h0;
			run_count <= KEY_COUNT_RESET;
			hash_start <= 1'b0;
			ev_done <= 1'b0;
			ev_match <= 1'b0;
			ev_nomatch <= 1'b0;
		end else begin
			hash_start <= 1'b0;
			ev_done <= 1'b0;
			ev_match <= 1'b0;
			ev_nomatch <= 1'b0;
			if (abort && !pending && state != S_IDLE) begin
				state <= S_IDLE;
			end else begin
				case (state)
					S_IDLE: begin
						// Starts during a run never reach here, so the live result is safe.
						if (start_trig) begin
							state <= S_ADDR;
							byte_cnt <= 4'h0;
							key_idx <= 4'h0;
							run_count <= key_count;
						end
					end
					S_ADDR: begin
						if (mem.rsp_valid) begin
							byte_cnt <= byte_cnt + 4'h1;
							if (byte_cnt == ADDR_BYTE_LAST) begin
								state <= S_KEY;
								byte_cnt <= 4'h0;
							end
						end
					end
					S_KEY: begin
						if (mem.rsp_valid) begin
							byte_cnt <= byte_cnt + 4'h1;
							if (byte_cnt == KEY_BYTE_LAST) begin
								state <= S_HASH;
								hash_start <= 1'b1;
							end
						end
					end
					S_HASH: begin
						if (hash_done) begin
							state <= S_WORK;
							byte_cnt <= 4'h0;
						end
					end
					S_WORK: begin
						if (mem.rsp_valid) begin
							byte_cnt <= byte_cnt + 4'h1;
							if (byte_cnt == HASH_BYTE_LAST) begin
								state <= S_CHECK;
							end
						end
					end
					S_CHECK: begin
						byte_cnt <= 4'h0;
						if (key_hit) begin
							state <= S_IDLE;
							ev_match <= 1'b1;
							ev_done <= 1'b1;
						end else if (last_key) begin
							state <= S_IDLE;
							ev_nomatch <= 1'b1;
							ev_done <= 1'b1;
						end else begin
							state <= S_KEY;
							key_idx <= key_idx + 4'h1;
						end
					end
					default: state <= S_IDLE;
				endcase
			end
		end
	end

	// Received address and key bytes shift in lowest address first.
	always_ff @(posedge I_CLK_SYS or negedge I_RESET_N) begin
		if (!I_RESET_N) begin
			addr_buf <= '0;
			key_buf <= '0;
		end else if (mem.rsp_valid && state == S_ADDR) begin
			addr_buf <= {mem.rsp_data, addr_buf[47:8]};
		end else if (mem.rsp_valid && state == S_KEY) begin
			key_buf <= {mem.rsp_data, key_buf[127:8]};
		end
	end

	always_ff @(posedge I_CLK_SYS or negedge I_RESET_N) begin
		if (!I_RESET_N) begin
			work_hash <= 24'h000000;
		end else if (hash_done && state == S_HASH) begin
			work_hash <= hash_val;
		end
	end

	always_ff @(posedge I_CLK_SYS or negedge I_RESET_N) begin
		if (!I_RESET_N) begin
			matched_key <= 4'h0;
		end else if (state == S_CHECK && key_hit && !abort) begin
			matched_key <= key_idx;
		end
	end

	// Event flags: a new event wins over a clearing write in the same cycle.
	logic [2:0] flags;
	logic [2:0] ev_set;
	logic [2:0] ev_clr;

	assign ev_set = {ev_nomatch, ev_match, ev_done} & {3{!abort}};
	assign ev_clr[BIT_DONE] = wr_fire && aw_addr == OFS_DONE && wr_zero0;
	assign ev_clr[BIT_MATCH] = wr_fire && aw_addr == OFS_MATCH && wr_zero0;
	assign ev_clr[BIT_NOMATCH] = wr_fire && aw_addr == OFS_NOMATCH && wr_zero0;

	always_ff @(posedge I_CLK_SYS or negedge I_RESET_N) begin
		if (!I_RESET_N) begin
			flags <= 3'h0;
		end else begin
			flags <= ev_set | (flags & ~ev_clr);
		end
	end

	assign O_IRQ = |(flags & irq_enable);

	// Read channel answers one cycle after the address is taken.
	assign O_ARREADY = !O_RVALID;

	always_ff @(posedge I_CLK_SYS or negedge I_RESET_N) begin
		if (!I_RESET_N) begin
			O_RVALID <= 1'b0;
			O_RDATA <= 32'h00000000;
			O_RRESP <= RESP_OKAY;
		end else if (I_ARVALID && !O_RVALID) begin
			O_RVALID <= 1'b1;
			O_RRESP <= reg_known(I_ARADDR) ? RESP_OKAY : RESP_SLVERR;
			case (I_ARADDR)
				OFS_DONE: O_RDATA <= {31'h00000000, flags[BIT_DONE]};
				OFS_MATCH: O_RDATA <= {31'h00000000, flags[BIT_MATCH]};
				OFS_NOMATCH: O_RDATA <= {31'h00000000, flags[BIT_NOMATCH]};
				OFS_IRQ_SET, OFS_IRQ_CLR: O_RDATA <= {29'h00000000, irq_enable};
				OFS_STATUS: O_RDATA <= {28'h0000000, matched_key};
				OFS_ON_OFF: O_RDATA <= {30'h00000000, on_off};
				OFS_KEY_COUNT: O_RDATA <= {27'h0000000, key_count};
				OFS_KEY_BASE: O_RDATA <= key_base;
				OFS_TARGET_BASE: O_RDATA <= target_base;
				OFS_WORK_BASE: O_RDATA <= work_base;
				default: O_RDATA <= 32'h00000000;
			endcase
		end else if (I_RREADY) begin
			O_RVALID <= 1'b0;
		end
	end
endmodule : par_top
